// *** src/fifo_host_ctrl.sv ***
// module: apb-controlled host that drives an asynchronous fifo through its pins
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
module fifo_host_ctrl #(
  parameter int DEVICES = 1
) (
  input wire logic clk_i, // 40 MHz system clock
  input wire logic sys_rst_i, // synchronous reset, active high
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic pwrite_i, // apb direction, high for write
  input wire logic [7:0] paddr_i, // apb byte address
  input wire logic [31:0] pwdata_i, // apb write data
  output logic [31:0] prdata_o, // apb read data
  output logic pready_o, // apb ready
  output logic pslverr_o, // apb error on unmapped address
  output fifo_host_pkg::dev_pins_type dev_pins_o, // strobes and data to the devices
  input wire logic [fifo_host_pkg::WORD_W-1:0] output_bus_i, // wired output bus
  input wire logic [DEVICES-1:0] full_flag_n_i, // per-device full flag
  input wire logic [DEVICES-1:0] empty_flag_n_i, // per-device empty flag
  input wire logic chain_out_or_halfway_n_i // half flag in standalone
);
  typedef enum logic [2:0] {S_IDLE, S_RESET, S_WRITE, S_READ, S_REPLAY} state_type;
  localparam int SW = fifo_host_pkg::WORD_W + 2 * DEVICES + 1;

  state_type state_reg;
  fifo_host_pkg::mode_type mode_reg;
  logic [1:0] cfg_reg;
  logic [fifo_host_pkg::WORD_W-1:0] wdata_reg;
  logic [fifo_host_pkg::WORD_W-1:0] rdata_reg;
  logic refused_reg;
  logic wrap_lost_reg;
  logic [11:0] writes_reg;
  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  fifo_host_pkg::dev_pins_type pins_reg;
  logic full_comp;
  logic empty_comp;
  logic half_n;
  logic setup;
  logic access_wr;
  logic cmd_go;
  logic start;
  logic refuse;
  logic [3:0] low_cyc;
  logic tmr_low;
  logic tmr_sample;
  logic tmr_done;
  logic [31:0] read_mux;
  logic mapped;

  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------
  // all device outputs are asynchronous; only sync2 is read by logic
  always_ff @(posedge clk_i) begin
    sync1_reg <= {output_bus_i, full_flag_n_i, empty_flag_n_i, chain_out_or_halfway_n_i};
    sync2_reg <= sync1_reg;
  end

  // an OR of active-low flags asserts only when every device asserts
  assign full_comp = |sync2_reg[2*DEVICES:DEVICES+1];
  assign empty_comp = |sync2_reg[DEVICES:1];
  // half flag exists only in standalone; cascade pin is the chain link
  assign half_n = (mode_reg == fifo_host_pkg::MODE_STANDALONE) ? sync2_reg[0] : 1'b1;

  // ----------------------------------------------------------------
  // apb slave: one setup, one access cycle, no wait states
  // ----------------------------------------------------------------
  assign setup = psel_i && !penable_i;
  assign access_wr = psel_i && penable_i && pready_reg && pwrite_i;
  assign cmd_go = access_wr && (paddr_i == fifo_host_pkg::CMD_OFF);
  assign mapped = (paddr_i <= fifo_host_pkg::CFG_OFF) && (paddr_i[1:0] == 2'h0);

  always_comb begin
    read_mux = 32'h0000_0000;
    unique case (paddr_i)
      fifo_host_pkg::WDATA_OFF: read_mux[fifo_host_pkg::WORD_W-1:0] = wdata_reg;
      fifo_host_pkg::RDATA_OFF: read_mux[fifo_host_pkg::WORD_W-1:0] = rdata_reg;
      fifo_host_pkg::STATUS_OFF: begin
        read_mux[fifo_host_pkg::ST_BUSY_BIT] = (state_reg != S_IDLE);
        read_mux[fifo_host_pkg::ST_EMPTY_N_BIT] = empty_comp;
        read_mux[fifo_host_pkg::ST_FULL_N_BIT] = full_comp;
        read_mux[fifo_host_pkg::ST_HALF_N_BIT] = half_n;
        read_mux[fifo_host_pkg::ST_REFUSED_BIT] = refused_reg;
        read_mux[fifo_host_pkg::ST_WRAP_BIT] = wrap_lost_reg;
        read_mux[fifo_host_pkg::ST_MODE_LSB +: 2] = mode_reg;
      end
      fifo_host_pkg::CFG_OFF: read_mux[1:0] = cfg_reg;
      default: read_mux = 32'h0000_0000;
    endcase
  end

  // answer registered in the setup cycle so pready rises in the access cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup && !mapped;
      prdata_reg <= (setup && !pwrite_i) ? read_mux : 32'h0000_0000;
    end
  end

  // software-written configuration and write data
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg_reg <= fifo_host_pkg::CFG_RESET;
      wdata_reg <= '0;
    end else if (access_wr) begin
      if (paddr_i == fifo_host_pkg::CFG_OFF) cfg_reg <= pwdata_i[1:0];
      if (paddr_i == fifo_host_pkg::WDATA_OFF) wdata_reg <= pwdata_i[fifo_host_pkg::WORD_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  // gating on flags: writes need not-full, reads need not-empty
  always_comb begin
    refuse = 1'b0;
    start = 1'b0;
    low_cyc = fifo_host_pkg::RESET_LOW;
    if (cmd_go && state_reg == S_IDLE) begin
      if (pwdata_i[fifo_host_pkg::CMD_RESET_BIT]) begin
        start = 1'b1;
      end else if (pwdata_i[fifo_host_pkg::CMD_WRITE_BIT]) begin
        start = full_comp;
        refuse = !full_comp;
        low_cyc = fifo_host_pkg::WRITE_LOW;
      end else if (pwdata_i[fifo_host_pkg::CMD_READ_BIT]) begin
        start = empty_comp;
        refuse = !empty_comp;
        low_cyc = fifo_host_pkg::READ_LOW;
      end else if (pwdata_i[fifo_host_pkg::CMD_REPLAY_BIT]) begin
        start = (mode_reg == fifo_host_pkg::MODE_STANDALONE);
        refuse = !start;
        low_cyc = fifo_host_pkg::REPLAY_LOW;
      end
    end else if (cmd_go) begin
      refuse = 1'b1; // busy: command dropped
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= S_IDLE;
    end else begin
      unique case (state_reg)
        S_IDLE: if (start) begin
          if (pwdata_i[fifo_host_pkg::CMD_RESET_BIT]) state_reg <= S_RESET;
          else if (pwdata_i[fifo_host_pkg::CMD_WRITE_BIT]) state_reg <= S_WRITE;
          else if (pwdata_i[fifo_host_pkg::CMD_READ_BIT]) state_reg <= S_READ;
          else state_reg <= S_REPLAY;
        end
        S_RESET, S_WRITE, S_READ, S_REPLAY: if (tmr_done) state_reg <= S_IDLE;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  strobe_timer #(.CNT_W(4)) u_timer (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(start),
    .low_cyc_i(low_cyc),
    .rec_cyc_i(fifo_host_pkg::SETTLE),
    .low_o(tmr_low),
    .sample_o(tmr_sample),
    .done_o(tmr_done)
  );

  // mode follows the straps held on the pins while the device is reset
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mode_reg <= fifo_host_pkg::MODE_STANDALONE;
    end else if (state_reg == S_RESET && tmr_done) begin
      if (!cfg_reg[fifo_host_pkg::CFG_CHAIN_BIT]) mode_reg <= fifo_host_pkg::MODE_STANDALONE;
      else if (cfg_reg[fifo_host_pkg::CFG_FL_BIT]) mode_reg <= fifo_host_pkg::MODE_SLAVE;
      else mode_reg <= fifo_host_pkg::MODE_MASTER;
    end
  end

  // read word taken while the strobe is still low and data has settled
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) rdata_reg <= '0;
    else if (state_reg == S_READ && tmr_sample) rdata_reg <= sync2_reg[SW-1:2*DEVICES+1];
  end

  // refused is sticky; a new refusal wins over a software clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) refused_reg <= 1'b0;
    else if (refuse) refused_reg <= 1'b1;
    else if (access_wr && paddr_i == fifo_host_pkg::STATUS_OFF
             && pwdata_i[fifo_host_pkg::ST_REFUSED_BIT]) refused_reg <= 1'b0;
  end

  // counts writes since device reset; past the depth a replay loses words
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || (state_reg == S_RESET)) begin
      writes_reg <= 12'h000;
      wrap_lost_reg <= 1'b0;
    end else if (state_reg == S_WRITE && tmr_done) begin
      if (writes_reg == fifo_host_pkg::DEPTH) wrap_lost_reg <= 1'b1;
      else writes_reg <= writes_reg + 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // device pins, all registered
  // ----------------------------------------------------------------
  // write, read and replay strobes each go low from their own state; in standalone reset with first-load clear the replay pin falls with init_n
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pins_reg <= '{init_n: 1'b1, write_n: 1'b1, read_n: 1'b1,
                    first_load_or_replay_n: 1'b1, chain_input: 1'b0, input_bus: '0};
    end else begin
      pins_reg.init_n <= !(state_reg == S_RESET && tmr_low);
      pins_reg.write_n <= !(state_reg == S_WRITE && tmr_low);
      pins_reg.read_n <= !(state_reg == S_READ && tmr_low);
      pins_reg.chain_input <= cfg_reg[fifo_host_pkg::CFG_CHAIN_BIT];
      pins_reg.input_bus <= wdata_reg;
      // standalone lets the pin rise with the reset pin, so no stray replay follows reset
      if (state_reg == S_RESET)
        pins_reg.first_load_or_replay_n <= cfg_reg[fifo_host_pkg::CFG_FL_BIT]
          || (!tmr_low && !cfg_reg[fifo_host_pkg::CFG_CHAIN_BIT]);
      else if (mode_reg == fifo_host_pkg::MODE_STANDALONE)
        pins_reg.first_load_or_replay_n <= !(state_reg == S_REPLAY && tmr_low);
    end
  end

  assign dev_pins_o = pins_reg;
  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence write_fall_s;
    $fell(pins_reg.write_n);
  endsequence
  sequence replay_pulse_s;
    (!pins_reg.first_load_or_replay_n) [*2] ##1 pins_reg.first_load_or_replay_n;
  endsequence

  chk_write_width: assert property (write_fall_s |-> (!pins_reg.write_n) [*2] ##1 pins_reg.write_n)
    else $error("write strobe width wrong");
  chk_write_gate: assert property (write_fall_s |-> $past(full_comp, 2))
    else $error("write issued while full");
  chk_read_gate: assert property ($fell(pins_reg.read_n) |-> $past(empty_comp, 2))
    else $error("read issued while empty");
  chk_read_width: assert property ($fell(pins_reg.read_n) |-> (!pins_reg.read_n) [*5] ##1 pins_reg.read_n)
    else $error("read strobe width wrong");
  chk_replay_quiet: assert property (($fell(pins_reg.first_load_or_replay_n) && state_reg == S_REPLAY)
    |-> (pins_reg.write_n && pins_reg.read_n) throughout replay_pulse_s)
    else $error("strobe active during replay pulse");
  chk_replay_mode: assert property ($fell(pins_reg.first_load_or_replay_n)
    |-> state_reg == S_RESET || mode_reg == fifo_host_pkg::MODE_STANDALONE)
    else $error("replay pulse in cascaded mode");
  chk_reset_width: assert property ($fell(pins_reg.init_n) |-> (!pins_reg.init_n) [*2] ##1 pins_reg.init_n)
    else $error("reset pulse width wrong");
  chk_reset_straps: assert property (!pins_reg.init_n |-> pins_reg.write_n && pins_reg.read_n
    && pins_reg.first_load_or_replay_n == cfg_reg[fifo_host_pkg::CFG_FL_BIT])
    else $error("straps or strobes wrong during reset");
  chk_apb_ready: assert property (setup |=> pready_reg ##1 !pready_reg)
    else $error("apb ready not one access cycle");
  chk_refuse_full: assert property ((cmd_go && state_reg == S_IDLE && !full_comp
    && pwdata_i[3:0] == 4'h2) |=> refused_reg && state_reg == S_IDLE)
    else $error("write to full fifo not refused");
endmodule // fifo_host_ctrl

// *** common/fifo_host_pkg.sv ***
// package: constants and types for the fifo host controller
package fifo_host_pkg;
  // ----------------------------------------------------------------
  // timing, all rounded up to whole 25 ns cycles
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int STROBE_LOW_NS = 50;
  localparam int RECOVERY_NS = 15;
  localparam int RESET_LOW_NS = 50;
  localparam int ACCESS_NS = 50;
  localparam int SYNC_STAGES = 2;
  localparam int STROBE_LOW_CYC = (STROBE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RECOVERY_CYC = (RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESET_LOW_CYC = (RESET_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACCESS_CYC = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // recovery also covers the flag resync so the next command sees fresh flags
  localparam int SETTLE_CYC = (RECOVERY_CYC > SYNC_STAGES + 2) ? RECOVERY_CYC : SYNC_STAGES + 2;
  localparam logic [3:0] WRITE_LOW = 4'(STROBE_LOW_CYC);
  localparam logic [3:0] READ_LOW = 4'(ACCESS_CYC + SYNC_STAGES + 1);
  localparam logic [3:0] REPLAY_LOW = 4'(STROBE_LOW_CYC);
  localparam logic [3:0] RESET_LOW = 4'(RESET_LOW_CYC);
  localparam logic [3:0] SETTLE = 4'(SETTLE_CYC);
  // ----------------------------------------------------------------
  // device geometry
  // ----------------------------------------------------------------
  localparam int WORD_W = 9;
  localparam logic [11:0] DEPTH = 12'h0800;
  // ----------------------------------------------------------------
  // register map (byte offsets) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_OFF = 8'h00;
  localparam logic [7:0] WDATA_OFF = 8'h04;
  localparam logic [7:0] RDATA_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0c;
  localparam logic [7:0] CFG_OFF = 8'h10;
  localparam int CMD_RESET_BIT = 0;
  localparam int CMD_WRITE_BIT = 1;
  localparam int CMD_READ_BIT = 2;
  localparam int CMD_REPLAY_BIT = 3;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_EMPTY_N_BIT = 1;
  localparam int ST_FULL_N_BIT = 2;
  localparam int ST_HALF_N_BIT = 3;
  localparam int ST_REFUSED_BIT = 4;
  localparam int ST_WRAP_BIT = 5;
  localparam int ST_MODE_LSB = 6;
  localparam int CFG_CHAIN_BIT = 0;
  localparam int CFG_FL_BIT = 1;
  localparam logic [1:0] CFG_RESET = 2'h0;
  typedef enum logic [1:0] {MODE_STANDALONE, MODE_MASTER, MODE_SLAVE} mode_type;
  // pins driven toward the device
  typedef struct packed {
    logic init_n;
    logic write_n;
    logic read_n;
    logic first_load_or_replay_n;
    logic chain_input;
    logic [WORD_W-1:0] input_bus;
  } dev_pins_type;
endpackage

// *** src/strobe_timer.sv ***
// module: two-phase strobe timer, low phase then recovery phase
`timescale 1ns/1ps
module strobe_timer #(
  parameter int CNT_W = 4
) (
  input wire logic clk_i, // system clock
  input wire logic sys_rst_i, // synchronous reset, active high
  input wire logic start_i, // begin a strobe, taken only while idle
  input wire logic [CNT_W-1:0] low_cyc_i, // cycles of low phase
  input wire logic [CNT_W-1:0] rec_cyc_i, // cycles of recovery phase
  output logic low_o, // low phase in progress
  output logic sample_o, // last cycle of low phase
  output logic done_o // last cycle of recovery
);
  typedef enum logic [1:0] {T_IDLE, T_LOW, T_REC} phase_type;
  phase_type phase_reg;
  logic [CNT_W-1:0] cnt_reg;

  // ----------------------------------------------------------------
  // phase sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      phase_reg <= T_IDLE;
      cnt_reg <= '0;
    end else begin
      unique case (phase_reg)
        T_IDLE: if (start_i) begin
          phase_reg <= T_LOW;
          cnt_reg <= low_cyc_i - 1'b1;
        end
        T_LOW: if (cnt_reg == '0) begin
          phase_reg <= T_REC;
          cnt_reg <= rec_cyc_i - 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 1'b1;
        end
        T_REC: if (cnt_reg == '0) begin
          phase_reg <= T_IDLE;
        end else begin
          cnt_reg <= cnt_reg - 1'b1;
        end
        default: phase_reg <= T_IDLE;
      endcase
    end
  end

  assign low_o = (phase_reg == T_LOW);
  assign sample_o = (phase_reg == T_LOW) && (cnt_reg == '0);
  assign done_o = (phase_reg == T_REC) && (cnt_reg == '0);
endmodule // strobe_timer

// *** tb/fifo_dev_model.sv ***
// device model: behavioural 2048x9 asynchronous fifo as seen from the host pins
`timescale 1ns/1ps
module fifo_dev_model (
  input wire fifo_host_pkg::dev_pins_type pins_i, // strobes and data from the host
  output logic [fifo_host_pkg::WORD_W-1:0] output_bus_o, // read data, scrambled when released
  output logic full_flag_n_o, // full flag, active low
  output logic empty_flag_n_o, // empty flag, active low
  output logic chain_out_or_halfway_n_o, // half flag, or chain output in cascade
  output logic strobe_clash_o // sticky: a strobe went low during replay
);
  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  logic [8:0] mem [0:2047];
  logic [10:0] wr_ptr;
  logic [10:0] rd_ptr;
  int count;
  logic cascaded;
  logic hand_off;
  // no pull-ups on the bus, so a read release never leaves the last word showing
  initial begin
    wr_ptr = 11'h000;
    rd_ptr = 11'h000;
    count = 0;
    cascaded = 1'b0;
    hand_off = 1'b0;
    strobe_clash_o = 1'b0;
    output_bus_o = 9'h1a5;
  end
  // ----------------------------------------------------------------
  // reset, mode capture, write, read, replay
  // ----------------------------------------------------------------
  // reset low: both pointers home, empty, bus released
  always @(negedge pins_i.init_n) begin
    wr_ptr = 11'h000;
    rd_ptr = 11'h000;
    count = 0;
    output_bus_o = ~output_bus_o;
  end
  // chain input decides standalone or cascade; first-load only splits master/slave
  always @(posedge pins_i.init_n) cascaded = pins_i.chain_input;
  // a lone device accepts every write while not full
  always @(negedge pins_i.write_n) begin
    if (pins_i.init_n && count < 2048) begin
      hand_off = cascaded && (wr_ptr == 11'h7ff);
      mem[wr_ptr] = pins_i.input_bus;
      wr_ptr = wr_ptr + 11'h001;
      count++;
    end
  end
  // read only while not empty; this device alone drives the bus
  always @(negedge pins_i.read_n) begin
    if (pins_i.init_n && count > 0) begin
      hand_off = cascaded && (rd_ptr == 11'h7ff);
      output_bus_o = mem[rd_ptr];
      rd_ptr = rd_ptr + 11'h001;
      count--;
    end
  end
  // the hand-off pulse on the chain output lasts as long as the strobe that caused it
  always @(posedge pins_i.write_n) hand_off = 1'b0;
  always @(posedge pins_i.read_n) begin
    output_bus_o = ~output_bus_o;
    hand_off = 1'b0;
  end
  // replay rewinds reads only; count is the distance to the kept write pointer
  always @(negedge pins_i.first_load_or_replay_n) begin
    if (pins_i.init_n && !cascaded) begin
      rd_ptr = 11'h000;
      count = int'(wr_ptr);
    end
  end
  // strobes must stay high while the replay strobe is low
  always @(pins_i) begin
    if (pins_i.init_n && !cascaded && !pins_i.first_load_or_replay_n &&
        (!pins_i.write_n || !pins_i.read_n)) begin
      strobe_clash_o = 1'b1;
    end
  end
  // flags from the unread count; no half flag in cascade; chain output high in reset
  assign empty_flag_n_o = (count != 0);
  assign full_flag_n_o = (count != 2048);
  assign chain_out_or_halfway_n_o = (!pins_i.init_n) ? 1'b1
    : (cascaded ? !hand_off : (count <= 1024));
endmodule // fifo_dev_model

// *** tb/tb_async_fifo_replay_cascade.sv ***
// testbench: apb-driven fifo host controller against the behavioural fifo model
`timescale 1ns/1ps
module tb_async_fifo_replay_cascade;
  logic clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  fifo_host_pkg::dev_pins_type dev_pins;
  logic [8:0] out_bus;
  logic [0:0] full_n, empty_n;
  logic half_n, clash;
  int fails, tests_run;

  fifo_host_ctrl #(.DEVICES(1)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .dev_pins_o(dev_pins),
    .output_bus_i(out_bus), .full_flag_n_i(full_n), .empty_flag_n_i(empty_n),
    .chain_out_or_halfway_n_i(half_n));
  fifo_dev_model dev (.pins_i(dev_pins), .output_bus_o(out_bus), .full_flag_n_o(full_n[0]),
    .empty_flag_n_o(empty_n[0]), .chain_out_or_halfway_n_o(half_n), .strobe_clash_o(clash));

  // ----------------------------------------------------------------
  // clock, watchdog, verdict
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // about 31k cycles are expected, so this only trips on a hang
  initial begin
    repeat (80000) @(posedge clk_i);
    fails++;
    print_verdict();
  end
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // apb master and helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // read just after the edge, before the design's updates land, so it is what that edge
  // sampled; the wait has no bound of its own, only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0000_0000, d, e);
  endtask
  // one command, then poll busy under a bound
  task automatic cmd(input int bitn);
    logic [31:0] s;
    int n;
    n = 0;
    wr(fifo_host_pkg::CMD_OFF, 32'h0000_0001 << bitn);
    do begin
      rd(fifo_host_pkg::STATUS_OFF, s);
      n++;
    end while (s[fifo_host_pkg::ST_BUSY_BIT] !== 1'b0 && n < 40);
    check("busy", 32'h0000_0000, {31'h0, s[fifo_host_pkg::ST_BUSY_BIT]});
  endtask
  // half_n, full_n, empty_n from the unread count
  function automatic logic [2:0] exp_flags(input int cnt, input logic casc);
    exp_flags = {casc || cnt <= 1024, cnt != 2048, cnt != 0};
  endfunction
  task automatic check_flags(input int cnt, input logic casc);
    logic [31:0] s;
    rd(fifo_host_pkg::STATUS_OFF, s);
    check("flags", {29'h0, exp_flags(cnt, casc)}, {29'h0, s[3:1]});
  endtask
  task automatic check_refused(input logic exp);
    logic [31:0] s;
    rd(fifo_host_pkg::STATUS_OFF, s);
    check("refused", {31'h0, exp}, {31'h0, s[fifo_host_pkg::ST_REFUSED_BIT]});
    wr(fifo_host_pkg::STATUS_OFF, 32'h0000_0010);
  endtask
  task automatic push(input logic [8:0] d);
    wr(fifo_host_pkg::WDATA_OFF, {23'h0, d});
    cmd(fifo_host_pkg::CMD_WRITE_BIT);
  endtask
  task automatic pop(input logic [8:0] d);
    logic [31:0] r;
    cmd(fifo_host_pkg::CMD_READ_BIT);
    rd(fifo_host_pkg::RDATA_OFF, r);
    check("read word", {23'h0, d}, r);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic e;
    logic [8:0] q[$];
    logic [1:0] cfg[3];
    fails = 0;
    tests_run = 0;
    sys_rst_i = 1'b1;
    {psel_i, penable_i, pwrite_i} = 3'h0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0000_0000;
    cfg = '{2'h1, 2'h3, 2'h0};
    void'($urandom(47));
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(fifo_host_pkg::CFG_OFF, r);
    check("cfg reset", 32'h0000_0000, r);
    check("idle pins", 32'h0000_001e, {27'h0, dev_pins[13:9]});
    apb(1'b0, 8'h14, 32'h0000_0000, r, e);
    check("unmapped error", 32'h0000_0001, {31'h0, e});
    check("unmapped data", 32'h0000_0000, r);
    cmd(fifo_host_pkg::CMD_RESET_BIT);
    check_flags(0, 1'b0);
    cmd(fifo_host_pkg::CMD_READ_BIT);
    check_refused(1'b1);
    // short block, partly read, then replayed twice over
    for (int i = 0; i < 6; i++) begin
      q.push_back(i == 0 ? 9'h1ff : 9'($urandom));
      push(q[i]);
    end
    for (int i = 0; i < 3; i++) pop(q[i]);
    for (int k = 0; k < 2; k++) begin
      cmd(fifo_host_pkg::CMD_REPLAY_BIT);
      check_flags(6, 1'b0);
      for (int i = 0; i < 6; i++) pop(q[i]);
      check_flags(0, 1'b0);
    end
    check("strobe clash", 32'h0000_0000, {31'h0, clash});
    // fill to the brim across every flag threshold
    cmd(fifo_host_pkg::CMD_RESET_BIT);
    for (int i = 1; i <= 2048; i++) begin
      push(i == 1 ? 9'h000 : 9'($urandom));
      if (i == 1 || i == 1024 || i == 1025 || i == 2047 || i == 2048) check_flags(i, 1'b0);
    end
    push(9'h155);
    check_refused(1'b1);
    pop(9'h000);
    check_flags(2047, 1'b0);
    push(9'h0aa);
    rd(fifo_host_pkg::STATUS_OFF, r);
    check("wrap lost", 32'h0000_0001, {31'h0, r[fifo_host_pkg::ST_WRAP_BIT]});
    // master, slave, then back to standalone
    for (int m = 0; m < 3; m++) begin
      wr(fifo_host_pkg::CFG_OFF, {30'h0, cfg[m]});
      cmd(fifo_host_pkg::CMD_RESET_BIT);
      rd(fifo_host_pkg::STATUS_OFF, r);
      check("mode", (m == 2) ? 32'h0 : 32'(m + 1), {30'h0, r[7:6]});
      check("wrap clear", 32'h0000_0000, {31'h0, r[fifo_host_pkg::ST_WRAP_BIT]});
      check("chain pin", {31'h0, cfg[m][0]}, {31'h0, dev_pins.chain_input});
      push(9'h0a5);
      cmd(fifo_host_pkg::CMD_REPLAY_BIT);
      check_refused(m != 2);
      check_flags(1, m != 2);
    end
    print_verdict();
  end
endmodule // tb_async_fifo_replay_cascade
